// ==== design/gsfl_input_sync.sv ====
// Purpose: Two-stage synchroniser with polarity correction for one general input
// Assumes: Input is asynchronous to clock
// Notes:   First stage feeds only the second stage
`timescale 1ns/1ps
`default_nettype none
module gsfl_input_sync (
    // Clock and reset
    input  wire logic clock,
    input  wire logic reset,
    // Pin and setting
    input  wire logic pinRaw,
    input  wire logic activeLow,
    // Corrected level
    output logic      asserted
);
    logic stage1Reg;
    logic stage2Reg;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            stage1Reg <= 1'b0;
            stage2Reg <= 1'b0;
        end else begin
            stage1Reg <= pinRaw;
            stage2Reg <= stage1Reg;
        end
    end

    assign asserted = stage2Reg ^ activeLow;
endmodule
`default_nettype wire

// ==== design/gsfl_pkg.sv ====
// Purpose: Shared constants and types for the general-input special function logic
// Assumes: 32-bit classic Wishbone register bus, one 200 MHz clock
// Notes:   Register offsets are byte addresses of aligned words
package gsfl_pkg;

    localparam int NUM_INPUTS = 32;
    localparam int NUM_RAILS  = 32;
    localparam int IDX_W      = 5;

    // Register byte offsets
    localparam logic [7:0] OFS_POLARITY  = 8'h00;
    localparam logic [7:0] OFS_SEQ_SRC   = 8'h04;
    localparam logic [7:0] OFS_FAULT_EN  = 8'h08;
    localparam logic [7:0] OFS_CLEAR_SRC = 8'h0c;
    localparam logic [7:0] OFS_DEBUG_SRC = 8'h10;
    localparam logic [7:0] OFS_BUS_EN    = 8'h14;
    localparam logic [7:0] OFS_ROLES     = 8'h18;
    localparam logic [7:0] OFS_MARGIN_EN = 8'h1c;
    localparam logic [7:0] OFS_IN_STATE  = 8'h20;
    localparam logic [7:0] OFS_STATUS    = 8'h24;
    localparam logic [7:0] OFS_PINSEL    = 8'h28;
    localparam logic [7:0] OFS_DEFINED   = 8'h2c;

    // Roles register fields
    localparam int ROLE_MEN_IDX  = 0;
    localparam int ROLE_MEN_VLD  = 5;
    localparam int ROLE_MSEL_IDX = 8;
    localparam int ROLE_MSEL_VLD = 13;

    // Status register fields
    localparam int ST_DEBUG    = 0;
    localparam int ST_MARGIN   = 1;
    localparam int ST_MLOW     = 2;
    localparam int ST_SUSPEND  = 3;
    localparam int ST_BUSDRIVE = 4;
    localparam int ST_ROLEREJ  = 5;

    localparam logic [31:0] RESET_ZERO = 32'h0000_0000;
    localparam int PIN_SEL_COUNT = 3;

    // Suppressible event classes
    typedef enum logic [3:0] {
        EV_OV_FAULT, EV_OV_WARN, EV_UV_FAULT, EV_UV_WARN,
        EV_TON_LIMIT, EV_TOFF_LIMIT, EV_OC_FAULT, EV_OC_WARN,
        EV_UC_FAULT, EV_OT_FAULT, EV_OT_WARN, EV_WATCHDOG,
        EV_RESEQ_ERR, EV_SEQ_TIMEOUT, EV_SLAVE_SD, EV_CFG_UPSET
    } gsfl_event_e;

    localparam int NUM_EVENTS = 16;

    typedef struct packed {
        logic [31:0] adr;
        logic [31:0] dat;
        logic [3:0]  sel;
        logic        we;
        logic        cyc;
        logic        stb;
    } gsfl_wb_req_s;

    typedef struct packed {
        logic        alertReq;
        logic        commFault;
        logic [NUM_EVENTS-1:0] eventHit;
    } gsfl_event_s;

    typedef struct packed {
        logic        marginActive;
        logic        marginLow;
    } gsfl_margin_s;

endpackage

// ==== design/gsfl_top.sv ====
// Purpose: General-input special function logic of a multi-rail power sequencer
// Assumes: Classic Wishbone slave, one clock, other blocks own sequencing and fault tables
// Notes:   All outputs registered; fault-bus pin is input/output/enable, enable low drives
// Behaviour
// - Each input has polarity; functions use corrected value.
// - Any input may be a sequencing dependency source.
// - First three defined inputs always feed pin-selected rail states.
// - Fault input de-assertion raises fault event for rail shutdown.
// - Clear-source input asserted clears latched status bits, except role-reject, which only a roles write with bit 15 set clears.
// - Margin-enable input asserted puts margining rails into margined state.
// - Margin-select asserted picks low, de-asserted picks high.
// - Debug blocks host alert, response and logging of listed events.
// - Debug ignores dependencies; rails sequence at timeout regardless of action.
// - Debug with zero timeout sequences immediately.
// - Debug stops fault pins driving fault bus low.
// - Entering debug restores logic outputs altered by suppressed events.
// - Debug suppresses input fault response but keeps other input functions.
// - Suppressed set covers voltage, time, current, temperature, watchdog, sequencing, upset.
// - Fault-bus role works only with fault enable also set.
// - Fault-bus pin monitors bus, driven low on local rail fault.
// - Fault-bus pin released once local fault clears.
// - Up to thirty-two general inputs supported.
// - On-dependency met while asserted, off-dependency while de-asserted.
// - Re-sequence suspended while any input fault behind it persists.
`timescale 1ns/1ps
`default_nettype none
module gsfl_top #(
    parameter int N_IN = gsfl_pkg::NUM_INPUTS
) (
    // Clock and reset
    input  wire logic                          clock,
    input  wire logic                          reset,
    // Wishbone slave
    input  wire gsfl_pkg::gsfl_wb_req_s        wbReq,
    output logic [31:0]                        wbDatO,
    output logic                               wbAck,
    // General input pins
    input  wire logic [N_IN-1:0]               inputPins,
    // Fault-bus pins: input, output, enable (low drives)
    input  wire logic [N_IN-1:0]               faultBusIn,
    output logic [N_IN-1:0]                    faultBusOut,
    output logic [N_IN-1:0]                    faultBusOeN,
    // From rail and sequencing blocks
    input  wire gsfl_pkg::gsfl_event_s         eventsIn,
    input  wire logic                          localRailFault,
    input  wire logic [N_IN-1:0]               reseqGpiCause,
    input  wire logic                          seqTimeoutExpired,
    input  wire logic                          seqTimeoutZero,
    input  wire logic                          depsMetIn,
    input  wire logic                          lgpoAlteredIn,
    // To sequencing, fault and status blocks
    output logic [N_IN-1:0]                    seqOnDepMet,
    output logic [N_IN-1:0]                    seqOffDepMet,
    output logic [gsfl_pkg::PIN_SEL_COUNT-1:0] pinSelState,
    output logic [N_IN-1:0]                    gpiFaultEvent,
    output logic                               clearLatched,
    output gsfl_pkg::gsfl_margin_s             marginCtrl,
    output logic                               debugMode,
    output logic                               hostAlert,
    output logic [gsfl_pkg::NUM_EVENTS-1:0]    eventRespond,
    output logic                               commFaultOut,
    output logic                               seqGo,
    output logic                               ignoreDeps,
    output logic                               lgpoRestore,
    output logic                               reseqSuspend,
    output logic                               faultBusSeen
);
    import gsfl_pkg::*;

    logic [N_IN-1:0] inAsserted;
    logic [N_IN-1:0] busSync1Reg;
    logic [N_IN-1:0] busSync2Reg;
    logic [31:0]     polarityReg;
    logic [31:0]     seqSrcReg;
    logic [31:0]     faultEnReg;
    logic [31:0]     clearSrcReg;
    logic [31:0]     debugSrcReg;
    logic [31:0]     busEnReg;
    logic [31:0]     definedReg;
    logic [IDX_W-1:0] menIdxReg;
    logic             menVldReg;
    logic [IDX_W-1:0] mselIdxReg;
    logic             mselVldReg;
    logic             roleRejReg;
    logic             marginEnSwReg;
    logic [31:0]      rdData;
    logic             debugNow;
    logic             debugPrevReg;
    logic [N_IN-1:0]  busRoleOk;
    logic [N_IN-1:0]  faultNow;
    logic [IDX_W-1:0] selIdx [PIN_SEL_COUNT];
    logic [PIN_SEL_COUNT-1:0] selVld;
    logic             wbHit;
    logic             wbWrite;

    for (genvar g = 0; g < N_IN; g++) begin : gIn
        gsfl_input_sync gsfl_input_sync_i (
            .clock     (clock),
            .reset     (reset),
            .pinRaw    (inputPins[g]),
            .activeLow (polarityReg[g]),
            .asserted  (inAsserted[g])
        );
    end

    // Fault-bus monitor synchroniser
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            busSync1Reg <= '0;
            busSync2Reg <= '0;
        end else begin
            busSync1Reg <= faultBusIn;
            busSync2Reg <= busSync1Reg;
        end
    end

    // Wishbone handshake: ack one cycle after request, dropped next cycle
    assign wbHit   = wbReq.cyc && wbReq.stb && !wbAck;
    assign wbWrite = wbHit && wbReq.we;

    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            wbAck  <= 1'b0;
            wbDatO <= RESET_ZERO;
        end else begin
            wbAck  <= wbHit;
            wbDatO <= wbHit ? rdData : RESET_ZERO;
        end
    end

    function automatic logic [31:0] bmerge(input logic [31:0] old, input logic [31:0] nw,
                                           input logic [3:0] sel);
        logic [31:0] r;
        r = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                r[b*8 +: 8] = nw[b*8 +: 8];
            end
        end
        return r;
    endfunction

    // Plain configuration registers
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            polarityReg   <= RESET_ZERO;
            seqSrcReg     <= RESET_ZERO;
            faultEnReg    <= RESET_ZERO;
            clearSrcReg   <= RESET_ZERO;
            debugSrcReg   <= RESET_ZERO;
            busEnReg      <= RESET_ZERO;
            definedReg    <= RESET_ZERO;
            marginEnSwReg <= 1'b0;
        end else if (wbWrite) begin
            case (wbReq.adr[7:0])
                OFS_POLARITY:  polarityReg <= bmerge(polarityReg, wbReq.dat, wbReq.sel);
                OFS_SEQ_SRC:   seqSrcReg   <= bmerge(seqSrcReg, wbReq.dat, wbReq.sel);
                OFS_FAULT_EN:  faultEnReg  <= bmerge(faultEnReg, wbReq.dat, wbReq.sel);
                OFS_CLEAR_SRC: clearSrcReg <= bmerge(clearSrcReg, wbReq.dat, wbReq.sel);
                OFS_DEBUG_SRC: debugSrcReg <= bmerge(debugSrcReg, wbReq.dat, wbReq.sel);
                OFS_BUS_EN:    busEnReg    <= bmerge(busEnReg, wbReq.dat, wbReq.sel);
                OFS_DEFINED:   definedReg  <= bmerge(definedReg, wbReq.dat, wbReq.sel);
                OFS_MARGIN_EN: begin
                    if (wbReq.sel[0]) begin
                        marginEnSwReg <= wbReq.dat[0];
                    end
                end
                default: ;
            endcase
        end
    end

    // margin roles: earliest kept, clear with bit 15 set
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            menIdxReg  <= '0;
            menVldReg  <= 1'b0;
            mselIdxReg <= '0;
            mselVldReg <= 1'b0;
            roleRejReg <= 1'b0;
        end else if (wbWrite && wbReq.adr[7:0] == OFS_ROLES && wbReq.sel[1:0] == 2'b11) begin
            if (wbReq.dat[15]) begin
                menVldReg  <= 1'b0;
                mselVldReg <= 1'b0;
                roleRejReg <= 1'b0;
            end else begin
                if (wbReq.dat[ROLE_MEN_VLD]) begin
                    if (!menVldReg) begin
                        menIdxReg <= wbReq.dat[ROLE_MEN_IDX +: IDX_W];
                        menVldReg <= 1'b1;
                    end else begin
                        roleRejReg <= 1'b1;
                    end
                end
                if (wbReq.dat[ROLE_MSEL_VLD]) begin
                    if (!mselVldReg) begin
                        mselIdxReg <= wbReq.dat[ROLE_MSEL_IDX +: IDX_W];
                        mselVldReg <= 1'b1;
                    end else begin
                        roleRejReg <= 1'b1;
                    end
                end
            end
        end
    end

    // first three defined inputs, by index order
    always_comb begin
        int k;
        k = 0;
        for (int s = 0; s < PIN_SEL_COUNT; s++) begin
            selIdx[s] = '0;
            selVld[s] = 1'b0;
        end
        for (int i = 0; i < N_IN; i++) begin
            if (definedReg[i] && k < PIN_SEL_COUNT) begin
                selIdx[k] = IDX_W'(i);
                selVld[k] = 1'b1;
                k = k + 1;
            end
        end
    end

    // debug while any debug input asserted
    assign debugNow = |(debugSrcReg[N_IN-1:0] & inAsserted);
    assign busRoleOk = busEnReg[N_IN-1:0] & faultEnReg[N_IN-1:0];
    // fault is de-assertion of a fault-enabled input
    assign faultNow = faultEnReg[N_IN-1:0] & ~inAsserted;

    always_comb begin
        rdData = RESET_ZERO;
        case (wbReq.adr[7:0])
            OFS_POLARITY:  rdData = polarityReg;
            OFS_SEQ_SRC:   rdData = seqSrcReg;
            OFS_FAULT_EN:  rdData = faultEnReg;
            OFS_CLEAR_SRC: rdData = clearSrcReg;
            OFS_DEBUG_SRC: rdData = debugSrcReg;
            OFS_BUS_EN:    rdData = busEnReg;
            OFS_DEFINED:   rdData = definedReg;
            OFS_MARGIN_EN: rdData[0] = marginEnSwReg;
            OFS_ROLES: begin
                rdData[ROLE_MEN_IDX +: IDX_W]  = menIdxReg;
                rdData[ROLE_MEN_VLD]           = menVldReg;
                rdData[ROLE_MSEL_IDX +: IDX_W] = mselIdxReg;
                rdData[ROLE_MSEL_VLD]          = mselVldReg;
            end
            OFS_IN_STATE:  rdData[N_IN-1:0] = inAsserted;
            OFS_STATUS: begin
                rdData[ST_DEBUG]    = debugMode;
                rdData[ST_MARGIN]   = marginCtrl.marginActive;
                rdData[ST_MLOW]     = marginCtrl.marginLow;
                rdData[ST_SUSPEND]  = reseqSuspend;
                rdData[ST_BUSDRIVE] = ~&faultBusOeN;
                rdData[ST_ROLEREJ]  = roleRejReg;
            end
            OFS_PINSEL:    rdData[PIN_SEL_COUNT-1:0] = pinSelState;
            default:       rdData = RESET_ZERO;
        endcase
    end

    // Input-derived outputs
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            seqOnDepMet   <= '0;
            seqOffDepMet  <= '0;
            pinSelState   <= '0;
            gpiFaultEvent <= '0;
            clearLatched  <= 1'b0;
            reseqSuspend  <= 1'b0;
            faultBusSeen  <= 1'b0;
        end else begin
            // dependency sources; on when asserted, off when de-asserted
            seqOnDepMet  <= seqSrcReg[N_IN-1:0] & inAsserted;
            seqOffDepMet <= seqSrcReg[N_IN-1:0] & ~inAsserted;
            for (int s = 0; s < PIN_SEL_COUNT; s++) begin
                pinSelState[s] <= selVld[s] & inAsserted[selIdx[s]];
            end
            gpiFaultEvent <= debugNow ? '0 : faultNow;
            // clear latched statuses; kept active in debug
            clearLatched  <= |(clearSrcReg[N_IN-1:0] & inAsserted);
            // hold re-sequence while its input fault persists
            reseqSuspend  <= |(reseqGpiCause & faultNow);
            faultBusSeen  <= |(busRoleOk & ~busSync2Reg);
        end
    end

    // Margin control
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            marginCtrl <= '0;
        end else begin
            marginCtrl.marginActive <= menVldReg & inAsserted[menIdxReg] & marginEnSwReg;
            // select low when asserted, high otherwise
            marginCtrl.marginLow    <= menVldReg & inAsserted[menIdxReg] & marginEnSwReg
                                       & mselVldReg & inAsserted[mselIdxReg];
        end
    end

    // Debug-mode filtering of events and sequencing
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            debugMode    <= 1'b0;
            debugPrevReg <= 1'b0;
            hostAlert    <= 1'b0;
            eventRespond <= '0;
            commFaultOut <= 1'b0;
            seqGo        <= 1'b0;
            ignoreDeps   <= 1'b0;
            lgpoRestore  <= 1'b0;
        end else begin
            debugMode    <= debugNow;
            debugPrevReg <= debugNow;
            // alert blocked, comm faults still alert
            hostAlert    <= (eventsIn.alertReq & ~debugNow) | eventsIn.commFault;
            eventRespond <= debugNow ? '0 : eventsIn.eventHit;
            commFaultOut <= eventsIn.commFault;
            ignoreDeps   <= debugNow;
            // timeout forces sequencing; zero timeout immediate
            seqGo        <= debugNow ? (seqTimeoutExpired | seqTimeoutZero) : depsMetIn;
            // restore on debug entry, then while in debug and outputs are altered
            lgpoRestore  <= debugNow & (lgpoAlteredIn | ~debugPrevReg);
        end
    end

    // Fault-bus drive, open drain: output always low, enable low drives
    always_ff @(posedge clock or posedge reset) begin
        if (reset) begin
            faultBusOut <= '0;
            faultBusOeN <= '1;
        end else begin
            faultBusOut <= '0;
            // drive on local fault; release on clear; not in debug
            faultBusOeN <= ~(busRoleOk & {N_IN{localRailFault & ~debugNow}});
        end
    end
endmodule
`default_nettype wire

// ==== tb/gsfl_board_model.sv ====
// Purpose: Board side of the shared fault bus
// Assumes: Pull-up on every bus line
// Notes:   Peers sink the line on the bench's command
`timescale 1ns/1ps
`default_nettype none
module gsfl_board_model
    import gsfl_pkg::*;
#(
    parameter int N_IN = NUM_INPUTS
) (
    // Peers pulling the bus
    input wire logic [N_IN-1:0] peerPull,
    // Design fault-bus pins
    input wire logic [N_IN-1:0] faultBusOut,
    input wire logic [N_IN-1:0] faultBusOeN,
    // Resolved line level
    output logic [N_IN-1:0]     busLevel
);
    // open-drain wired level
    // Pull-up wins unless any party sinks the line
    assign busLevel = ~(peerPull | (~faultBusOeN & ~faultBusOut));
endmodule
`default_nettype wire

// ==== tb/gsfl_top_assertions.sv ====
// Purpose: Port-level checks for the general-input function block
// Assumes: All outputs registered, one clock
// Notes:   Bound from the bench
`timescale 1ns/1ps
`default_nettype none
module gsfl_top_assertions
    import gsfl_pkg::*;
#(
    parameter int N_IN = NUM_INPUTS
) (
    // Clock and reset
    input wire logic                   clock,
    input wire logic                   reset,
    // Bus
    input wire gsfl_pkg::gsfl_wb_req_s wbReq,
    input wire logic                   wbAck,
    // Fault side
    input wire gsfl_pkg::gsfl_event_s  eventsIn,
    input wire logic                   localRailFault,
    input wire logic [N_IN-1:0]        faultBusOut,
    input wire logic [N_IN-1:0]        faultBusOeN,
    // Status outputs
    input wire gsfl_pkg::gsfl_margin_s marginCtrl,
    input wire logic                   debugMode,
    input wire logic                   hostAlert,
    input wire logic [NUM_EVENTS-1:0]  eventRespond,
    input wire logic                   commFaultOut,
    input wire logic                   ignoreDeps
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (reset);

    sequence s_take;
        wbReq.cyc && wbReq.stb && !wbAck;
    endsequence
    sequence s_pulse;
        wbAck ##1 !wbAck;
    endsequence

    property p_ackAnswer;
        s_take |=> s_pulse;
    endproperty
    a_ackAnswer: assert property (p_ackAnswer) else $error("bad ack");

    // Comm faults still alert in debug, so only a quiet comm path counts
    property p_quietAlert;
        debugMode && !$past(eventsIn.commFault) |-> !hostAlert;
    endproperty
    a_quietAlert: assert property (p_quietAlert) else $error("alert in debug");

    property p_quietEvents;
        debugMode |-> eventRespond == '0;
    endproperty
    a_quietEvents: assert property (p_quietEvents) else $error("event in debug");

    property p_commKept;
        eventsIn.commFault |=> commFaultOut;
    endproperty
    a_commKept: assert property (p_commKept) else $error("comm fault lost");

    property p_ignoreDeps;
        $rose(debugMode) |-> ignoreDeps;
    endproperty
    a_ignoreDeps: assert property (p_ignoreDeps) else $error("deps kept in debug");

    property p_debugNoBus;
        debugMode |-> &faultBusOeN;
    endproperty
    a_debugNoBus: assert property (p_debugNoBus) else $error("bus driven in debug");

    property p_busOnlyLow;
        faultBusOut == '0;
    endproperty
    a_busOnlyLow: assert property (p_busOnlyLow) else $error("bus driven high");

    property p_busRelease;
        !localRailFault [*2] |-> &faultBusOeN;
    endproperty
    a_busRelease: assert property (p_busRelease) else $error("bus held");

    property p_lowNeedsActive;
        marginCtrl.marginLow |-> marginCtrl.marginActive;
    endproperty
    a_lowNeedsActive: assert property (p_lowNeedsActive) else $error("low without margin");
endmodule
`default_nettype wire

// ==== tb/gsfl_top_bench.sv ====
// Purpose: Self-checking bench for the general-input function block
// Assumes: Pins settle in three edges
// Notes:   Scenarios share pins, so they run in order
`timescale 1ns/1ps
`default_nettype none
module gsfl_top_bench;
    import gsfl_pkg::*;
    logic                clock = 1'h0;
    logic                reset = 1'h1;
    gsfl_wb_req_s        wbReq = '0;
    gsfl_event_s         eventsIn = '0;
    logic [31:0]         inputPins = '0, peerPull = '0, reseqGpiCause = '0;
    logic                localRailFault = 1'h0, seqTimeoutExpired = 1'h0, seqTimeoutZero = 1'h0;
    logic                depsMetIn = 1'h0, lgpoAlteredIn = 1'h0;
    logic [31:0]         wbDatO, faultBusIn, faultBusOut, faultBusOeN, seqOnDepMet, seqOffDepMet, gpiFaultEvent;
    logic [2:0]          pinSelState;
    logic [15:0]         eventRespond;
    gsfl_margin_s        marginCtrl;
    logic                wbAck, clearLatched, debugMode, hostAlert, commFaultOut, seqGo;
    logic                ignoreDeps, lgpoRestore, reseqSuspend, faultBusSeen;
    int                  err_total = 0, samples_checked = 0;

    always #2.5 clock = ~clock;
    gsfl_top #(.N_IN(NUM_INPUTS)) gsfl_top_i (.clock(clock), .reset(reset), .wbReq(wbReq), .wbDatO(wbDatO),
        .wbAck(wbAck), .inputPins(inputPins), .faultBusIn(faultBusIn), .faultBusOut(faultBusOut),
        .faultBusOeN(faultBusOeN), .eventsIn(eventsIn), .localRailFault(localRailFault),
        .reseqGpiCause(reseqGpiCause), .seqTimeoutExpired(seqTimeoutExpired), .seqTimeoutZero(seqTimeoutZero),
        .depsMetIn(depsMetIn), .lgpoAlteredIn(lgpoAlteredIn), .seqOnDepMet(seqOnDepMet),
        .seqOffDepMet(seqOffDepMet), .pinSelState(pinSelState), .gpiFaultEvent(gpiFaultEvent),
        .clearLatched(clearLatched), .marginCtrl(marginCtrl), .debugMode(debugMode), .hostAlert(hostAlert),
        .eventRespond(eventRespond), .commFaultOut(commFaultOut), .seqGo(seqGo), .ignoreDeps(ignoreDeps),
        .lgpoRestore(lgpoRestore), .reseqSuspend(reseqSuspend), .faultBusSeen(faultBusSeen));

    gsfl_board_model #(.N_IN(NUM_INPUTS)) gsfl_board_model_i (.peerPull(peerPull),
        .faultBusOut(faultBusOut), .faultBusOeN(faultBusOeN), .busLevel(faultBusIn));
    task automatic wrap_up();
        $display("Checks %0d mismatches %0d", samples_checked, err_total);
        if (err_total == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask

    // Holds until ack is sampled, then idles a cycle
    task automatic wb(input logic [7:0] a, input logic we, input logic [31:0] d, output logic [31:0] rd);
        int n;
        wbReq <= '{adr: {24'h0, a}, dat: d, sel: 4'hf, we: we, cyc: 1'h1, stb: 1'h1};
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (wbAck !== 1'h1 && n < 50);
        rd = wbDatO;
        wbReq <= '0;
        @(posedge clock);
        if (n >= 50) begin
            err_total++;
            $display("Error bus ack expected 1 seen timeout");
            wrap_up();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(a, 1'h1, d, x);
    endtask

    task automatic rdchk(input string what, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] x;
        wb(a, 1'h0, '0, x);
        chk(what, exp, x);
    endtask

    // Pin change needs three edges
    task automatic settle();
        repeat (4) @(posedge clock);
    endtask

    task automatic t_regs();
        rdchk("polarity", OFS_POLARITY, RESET_ZERO);
        rdchk("status", OFS_STATUS, RESET_ZERO);
        wr(8'h80, 32'hffff_ffff);
        rdchk("unmapped", 8'h80, RESET_ZERO);
        wr(OFS_SEQ_SRC, 32'hffff_ffff);
        rdchk("seqSrc", OFS_SEQ_SRC, 32'hffff_ffff);
    endtask

    task automatic t_polarity();
        inputPins <= 32'h0000_00a5;
        settle();
        chk("onDep", 32'h0000_00a5, seqOnDepMet);
        chk("offDep", 32'hffff_ff5a, seqOffDepMet);
        wr(OFS_POLARITY, 32'h0000_00ff);
        settle();
        chk("onDepLow", 32'h0000_005a, seqOnDepMet);
        rdchk("inState", OFS_IN_STATE, 32'h0000_005a);
        wr(OFS_POLARITY, RESET_ZERO);
    endtask

    task automatic t_pinsel();
        wr(OFS_DEFINED, 32'h8000_0310);
        inputPins <= 32'h8000_0210;
        settle();
        chk("pinSel", 32'h5, 32'(pinSelState));
    endtask

    task automatic t_fault();
        wr(OFS_FAULT_EN, 32'h5);
        wr(OFS_BUS_EN, 32'h7);
        inputPins <= 32'h0;
        reseqGpiCause <= 32'h1;
        settle();
        chk("faultEv", 32'h5, gpiFaultEvent);
        chk("suspend", 32'h1, 32'(reseqSuspend));
        localRailFault <= 1'h1;
        settle();
        chk("busDrive", 32'hffff_fffa, faultBusOeN);
        inputPins <= 32'h1;
        localRailFault <= 1'h0;
        settle();
        chk("busFree", 32'hffff_ffff, faultBusOeN);
        chk("resume", 32'h0, 32'(reseqSuspend));
        peerPull <= 32'h4;
        settle();
        chk("busSeen", 32'h1, 32'(faultBusSeen));
        peerPull <= 32'h0;
        reseqGpiCause <= 32'h0;
    endtask

    task automatic t_clear();
        wr(OFS_CLEAR_SRC, 32'h8);
        inputPins <= 32'h0000_000d;
        settle();
        chk("clear", 32'h1, 32'(clearLatched));
        inputPins <= 32'h0000_0005;
        settle();
        chk("clearOff", 32'h0, 32'(clearLatched));
    endtask

    task automatic t_margin();
        wr(OFS_MARGIN_EN, 32'h1);
        wr(OFS_ROLES, 32'h0000_2625);
        inputPins <= 32'h0000_0065;
        settle();
        chk("marginLow", 32'h3, 32'(marginCtrl));
        inputPins <= 32'h0000_0025;
        settle();
        chk("marginHigh", 32'h2, 32'(marginCtrl));
        wr(OFS_ROLES, 32'h0000_0027);
        inputPins <= 32'h0000_0085;
        settle();
        chk("marginKept", 32'h0, 32'(marginCtrl));
        rdchk("reject", OFS_STATUS, 32'h20);
        wr(OFS_ROLES, 32'h0000_8000);
    endtask

    task automatic t_debug();
        wr(OFS_DEBUG_SRC, 32'h80);
        eventsIn <= '{alertReq: 1'h1, commFault: 1'h0, eventHit: 16'hffff};
        localRailFault <= 1'h1;
        inputPins <= 32'h0000_0004;
        settle();
        chk("respond", 32'hffff, 32'(eventRespond));
        chk("alert", 32'h1, 32'(hostAlert));
        lgpoAlteredIn <= 1'h1;
        seqTimeoutZero <= 1'h1;
        inputPins <= 32'h0000_0084;
        settle();
        chk("alertDbg", 32'h0, 32'(hostAlert));
        chk("respondDbg", 32'h0, 32'(eventRespond));
        chk("faultDbg", 32'h0, gpiFaultEvent);
        chk("depDbg", 32'h0000_0084, seqOnDepMet);
        chk("seqGoZero", 32'h1, 32'(seqGo));
        chk("ignore", 32'h1, 32'(ignoreDeps));
        chk("busDbg", 32'hffff_ffff, faultBusOeN);
        chk("restore", 32'h1, 32'(lgpoRestore));
        seqTimeoutZero <= 1'h0;
        seqTimeoutExpired <= 1'h1;
        eventsIn.commFault <= 1'h1;
        settle();
        chk("seqGoExp", 32'h1, 32'(seqGo));
        chk("comm", 32'h1, 32'(commFaultOut));
        chk("alertComm", 32'h1, 32'(hostAlert));
    endtask

    initial begin
        repeat (5) @(posedge clock);
        reset <= 1'h0;
        @(posedge clock);
        t_regs();
        t_polarity();
        t_pinsel();
        t_fault();
        t_clear();
        t_margin();
        t_debug();
        wrap_up();
    end
endmodule

bind gsfl_top gsfl_top_assertions #(.N_IN(N_IN)) gsfl_top_assertions_i (.clock(clock), .reset(reset),
    .wbReq(wbReq), .wbAck(wbAck), .eventsIn(eventsIn), .localRailFault(localRailFault),
    .faultBusOut(faultBusOut), .faultBusOeN(faultBusOeN), .marginCtrl(marginCtrl), .debugMode(debugMode),
    .hostAlert(hostAlert), .eventRespond(eventRespond), .commFaultOut(commFaultOut), .ignoreDeps(ignoreDeps));
`default_nettype wire
